// ==== bench/pms_cpu_model.sv ====
`timescale 1ns/1ps
// Pipeline and bus side of the sequencer
module pms_cpu_model
(
  // Clock
  input wire logic clk,
  // Instruction and bus status
  output logic [1:0] writeback_stage_op,
  output logic system_bus_idle
);
  // Nothing in writeback, bus idle
  initial
  begin
    writeback_stage_op = 2'h0;
    system_bus_idle = 1'b1;
  end
  // One instruction in writeback; bus stays busy for busy cycles after it
  task automatic issue(input logic [1:0] op, input int busy);
    @(posedge clk);
    writeback_stage_op <= op;
    system_bus_idle <= (busy == 0);
    @(posedge clk);
    writeback_stage_op <= 2'h0;
    repeat (busy) @(posedge clk);
    system_bus_idle <= 1'b1;
  endtask
endmodule

// ==== bench/pms_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module pms_sequencer_tb_top;
  import pms_pkg::*;
  // Expected output sets: mode, four holds, stall
  localparam logic [8:0] FULL = 9'h020, STBY = 9'h043, SUSP = 9'h087, HIB = 9'h11f, PEND = 9'h021;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic int_accept = 1'b0;
  logic wake_timer_int = 1'b0;
  logic power_switch_pin = 1'b0;
  logic carrier_detect_input_pin = 1'b0;
  logic [1:0] op;
  logic idle, h_pipe, h_peri, h_mast, h_pll, stall;
  logic [3:0] mode;
  logic [8:0] outs;
  int err_count = 0;
  int checks_done = 0;
  // Hold order matches the expected sets: pll, master, peripheral, pipeline
  assign outs = {mode, h_pll, h_mast, h_peri, h_pipe, stall};
  // Clock, 25 ns period
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  pms_cpu_model cpu (.clk(clk), .writeback_stage_op(op), .system_bus_idle(idle));
  pms_sequencer dut (.clk(clk), .resetn(resetn), .writeback_stage_op(op), .system_bus_idle(idle),
    .int_accept(int_accept), .wake_timer_int(wake_timer_int), .power_switch_pin(power_switch_pin),
    .carrier_detect_input_pin(carrier_detect_input_pin), .pipeline_clk_hold(h_pipe),
    .peripheral_interface_clock_hold(h_peri), .master_output_clock_hold(h_mast),
    .pll_timer_clk_hold(h_pll), .pipeline_stall(stall), .power_mode(mode));
  // Compare one result
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Compare one wake latency in clock edges
  task automatic chk_lat(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t wake latency %0d expected %0d", $time, got, exp);
    end
  endtask
  // Raise a wake source, count edges until full speed (8 = ignored)
  task automatic wake(input int src, input logic [8:0] lat);
    int n;
    @(posedge clk);
    int_accept <= (src == 0);
    wake_timer_int <= (src == 1);
    power_switch_pin <= (src == 2);
    carrier_detect_input_pin <= (src == 3);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (mode !== 4'h1 && n < 8);
    chk_lat(9'(n), lat);
    if (lat != 9'h8)
      chk(outs, FULL);
    @(posedge clk);
    {int_accept, wake_timer_int, power_switch_pin, carrier_detect_input_pin} <= 4'h0;
  endtask
  // Suspend behind a busy bus, refused second op, wrong and right wakes
  task automatic t_suspend();
    cpu.issue(2'h2, 3);
    #1 chk(outs, PEND);
    @(posedge clk);
    #1 chk(outs, SUSP);
    cpu.issue(2'h3, 0);
    @(posedge clk);
    #1 chk(outs, SUSP);
    wake(2, 9'h8);
    wake(0, 9'h1);
  endtask
  // Hibernate, woken by each of its three sources
  task automatic t_hibernate();
    for (int s = 1; s < 4; s++)
    begin
      cpu.issue(2'h3, 0);
      @(posedge clk);
      #1 chk(outs, HIB);
      if (s == 1)
        wake(0, 9'h8);
      wake(s, (s == 1) ? 9'h1 : 9'h3);
    end
  endtask
  // Standby, woken by interrupt and by timer, pin ignored
  task automatic t_standby();
    for (int s = 0; s < 2; s++)
    begin
      cpu.issue(2'h1, 0);
      @(posedge clk);
      #1 chk(outs, STBY);
      if (s == 0)
        wake(3, 9'h8);
      wake(s, 9'h1);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(outs, FULL);
    t_suspend();
    t_hibernate();
    t_standby();
    results();
  end
  // Watchdog, well beyond the fewer than a hundred cycles needed
  initial
  begin
    #40000;
    err_count++;
    results();
  end
endmodule

// ==== hdl/pms_sequencer.sv ====
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_sequencer
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pipeline and bus status
  input wire logic [1:0] writeback_stage_op,
  input wire logic system_bus_idle,
  // Wake sources
  input wire logic int_accept,
  input wire logic wake_timer_int,
  input wire logic power_switch_pin,
  input wire logic carrier_detect_input_pin,
  // Clock gate controls, pipeline stall and power mode
  output logic pipeline_clk_hold,
  output logic peripheral_interface_clock_hold,
  output logic master_output_clock_hold,
  output logic pll_timer_clk_hold,
  output logic pipeline_stall,
  output logic [3:0] power_mode
);
  // Reset synchroniser
  logic rst_meta_r;
  logic rst_n_r;
  // Synchronised pins
  logic [1:0] pins_s;
  // Mode state
  pms_mode_t mode_r;
  pms_mode_t mode_nxt;
  // Pending instruction held until bus is idle
  logic [1:0] pend_r;
  logic [1:0] pend_nxt;

  // Release reset through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pin synchronisation
  pms_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n_r),
    .d({power_switch_pin, carrier_detect_input_pin}),
    .q(pins_s)
  );

  // Hibernate wake condition
  function automatic logic hib_wake(input logic [1:0] p, input logic t);
    hib_wake = p[1] | p[0] | t;
  endfunction

  // Next mode and pending instruction
  always_comb
  begin
    mode_nxt = mode_r;
    pend_nxt = pend_r;
    case (mode_r)
      PMS_FULL:
      begin
        // Latch instruction as it reaches writeback
        if (pend_r == `PMS_OP_NONE && writeback_stage_op != `PMS_OP_NONE)
          pend_nxt = writeback_stage_op;
        // Commit once bus is idle
        if (pend_r != `PMS_OP_NONE && system_bus_idle)
        begin
          pend_nxt = `PMS_OP_NONE;
          if (pend_r == `PMS_OP_SUSPEND)
            mode_nxt = PMS_SUSPEND;
          else if (pend_r == `PMS_OP_HIBERNATE)
            mode_nxt = PMS_HIBERNATE;
          else
            mode_nxt = PMS_STANDBY;
        end
      end
      PMS_STANDBY:
      begin
        // Any interrupt, timer included
        if (int_accept | wake_timer_int)
          mode_nxt = PMS_FULL;
      end
      PMS_SUSPEND:
      begin
        if (int_accept)
          mode_nxt = PMS_FULL;
      end
      PMS_HIBERNATE:
      begin
        if (hib_wake(pins_s, wake_timer_int))
          mode_nxt = PMS_FULL;
      end
      default:
      begin
        // Illegal code falls back to full speed
        mode_nxt = PMS_FULL;
        pend_nxt = `PMS_OP_NONE;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      mode_r <= PMS_FULL;
      pend_r <= `PMS_OP_NONE;
    end
    else
    begin
      mode_r <= mode_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Clock hold outputs from the next mode, registered
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pipeline_clk_hold <= 1'b0;
      peripheral_interface_clock_hold <= 1'b0;
      master_output_clock_hold <= 1'b0;
      pll_timer_clk_hold <= 1'b0;
      pipeline_stall <= 1'b0;
      power_mode <= PMS_FULL;
    end
    else
    begin
      // Pipeline clock stops in every low-power mode
      pipeline_clk_hold <= (mode_nxt != PMS_FULL);
      // Peripheral clock stops in suspend and hibernate
      peripheral_interface_clock_hold <= (mode_nxt == PMS_SUSPEND) | (mode_nxt == PMS_HIBERNATE);
      // Master and PLL clocks stop only in hibernate
      master_output_clock_hold <= (mode_nxt == PMS_HIBERNATE);
      pll_timer_clk_hold <= (mode_nxt == PMS_HIBERNATE);
      // Stall from commit-pending until wake
      pipeline_stall <= (mode_nxt != PMS_FULL) | (pend_nxt != `PMS_OP_NONE);
      power_mode <= mode_nxt;
    end
  end

  // Entry only with idle bus
  property p_entry_idle;
    @(posedge clk) disable iff (!rst_n_r)
    (mode_r == PMS_FULL && mode_nxt != PMS_FULL) |-> system_bus_idle && pend_r != `PMS_OP_NONE;
  endproperty
  a_entry_idle: assert property (p_entry_idle) else $error("low-power entry without idle bus");

  // Suspend instruction reaches suspend
  property p_susp;
    @(posedge clk) disable iff (!rst_n_r)
    (mode_r == PMS_FULL && pend_r == `PMS_OP_SUSPEND && system_bus_idle) |=> mode_r == PMS_SUSPEND;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not entered");

  // Suspend clock pattern
  property p_susp_clk;
    @(posedge clk) disable iff (!rst_n_r)
    mode_r == PMS_SUSPEND |-> pipeline_clk_hold && peripheral_interface_clock_hold;
  endproperty
  a_susp_clk: assert property (p_susp_clk) else $error("suspend clocks not held");

  // Suspend keeps master and PLL clocks
  property p_susp_run;
    @(posedge clk) disable iff (!rst_n_r)
    mode_r == PMS_SUSPEND |-> !master_output_clock_hold && !pll_timer_clk_hold;
  endproperty
  a_susp_run: assert property (p_susp_run) else $error("suspend stopped master clock");

  // Interrupt ends suspend next cycle
  property p_susp_wake;
    @(posedge clk) disable iff (!rst_n_r)
    (mode_r == PMS_SUSPEND && int_accept) |=> mode_r == PMS_FULL && !pipeline_clk_hold;
  endproperty
  a_susp_wake: assert property (p_susp_wake) else $error("suspend did not wake");

  // Hibernate holds all clocks
  property p_hib_clk;
    @(posedge clk) disable iff (!rst_n_r)
    mode_r == PMS_HIBERNATE |-> pipeline_clk_hold && master_output_clock_hold && pll_timer_clk_hold
      && peripheral_interface_clock_hold;
  endproperty
  a_hib_clk: assert property (p_hib_clk) else $error("hibernate clock running");

  // Hibernate wake sources
  property p_hib_wake;
    @(posedge clk) disable iff (!rst_n_r)
    (mode_r == PMS_HIBERNATE && (wake_timer_int || pins_s != 2'h0)) |=> mode_r == PMS_FULL;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate did not wake");

  // Standby holds only pipeline clock
  property p_stby;
    @(posedge clk) disable iff (!rst_n_r)
    mode_r == PMS_STANDBY |-> pipeline_clk_hold && !peripheral_interface_clock_hold && !master_output_clock_hold;
  endproperty
  a_stby: assert property (p_stby) else $error("standby clock pattern wrong");

  // Low-power modes exit only to full speed
  property p_one_mode;
    @(posedge clk) disable iff (!rst_n_r)
    (mode_r != PMS_FULL && mode_nxt != mode_r) |-> mode_nxt == PMS_FULL;
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode change not from full speed");
endmodule

// ==== hdl/pms_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for asynchronous pin levels
module pms_sync
  import pms_pkg::*;
#(
  parameter int W = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta_r;

  // Two-stage capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== include/pms_defs.svh ====
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// Clock gate forcing levels and pipeline control
`define PMS_CLK_FORCED 1'b1
// Stage encoding of the power-mode instruction in writeback
`define PMS_OP_NONE 2'h0
`define PMS_OP_STANDBY 2'h1
`define PMS_OP_SUSPEND 2'h2
`define PMS_OP_HIBERNATE 2'h3
// Cycles the resume request stays pending before mode is left
`define PMS_WAKE_SETTLE 2'h1

`endif

// ==== include/pms_pkg.sv ====
package pms_pkg;
  // Power modes, one-hot
  typedef enum logic [3:0] {
    PMS_FULL = 4'h1,
    PMS_STANDBY = 4'h2,
    PMS_SUSPEND = 4'h4,
    PMS_HIBERNATE = 4'h8
  } pms_mode_t;
endpackage
